// ### pkg/pd_phy_regs_pkg.sv
// constants and types for the capability, header and receive-detect registers
package pd_phy_regs_pkg;
	localparam logic [7:0] ADDR_EXT_CAP_UPPER = 8'h27;
	localparam logic [7:0] ADDR_INPUT_CAP     = 8'h28;
	localparam logic [7:0] ADDR_OUTPUT_CAP    = 8'h29;
	localparam logic [7:0] ADDR_MSG_HDR_CFG   = 8'h2e;
	localparam logic [7:0] ADDR_RX_KIND_EN    = 8'h2f;

	localparam logic [7:0] RST_EXT_CAP_UPPER = 8'h00;
	localparam logic [7:0] RST_INPUT_CAP     = 8'h00;
	localparam logic [7:0] RST_OUTPUT_CAP    = 8'h00;
	localparam logic [7:0] RST_MSG_HDR_CFG   = 8'h02;
	localparam logic [7:0] RST_RX_KIND_EN    = 8'h00;
	localparam logic [7:0] RX_KIND_EN_MASK   = 8'h7f;

	localparam int HDR_POWER_ROLE_BIT = 0;
	localparam int HDR_REV_LSB        = 1;
	localparam int HDR_DATA_ROLE_BIT  = 3;
	localparam int HDR_CABLE_PLUG_BIT = 4;

	localparam int EN_PLAIN_BIT        = 0;
	localparam int EN_SINGLE_BIT       = 1;
	localparam int EN_DOUBLE_BIT       = 2;
	localparam int EN_DBG_SINGLE_BIT   = 3;
	localparam int EN_DBG_DOUBLE_BIT   = 4;
	localparam int EN_HARD_RESET_BIT   = 5;
	localparam int EN_CABLE_RESET_BIT  = 6;

	localparam logic [1:0] REV_1_0 = 2'h0;
	localparam logic [1:0] REV_2_0 = 2'h1;
	localparam logic [1:0] REV_3_0 = 2'h2;

	// kind codes as the receiver front end reports them
	localparam logic [2:0] KIND_PLAIN       = 3'h0;
	localparam logic [2:0] KIND_SINGLE      = 3'h1;
	localparam logic [2:0] KIND_DOUBLE      = 3'h2;
	localparam logic [2:0] KIND_DBG_SINGLE  = 3'h3;
	localparam logic [2:0] KIND_DBG_DOUBLE  = 3'h4;
	localparam logic [2:0] KIND_HARD_RESET  = 3'h5;
	localparam logic [2:0] KIND_CABLE_RESET = 3'h6;

	typedef struct packed {
		logic       cable_plug;
		logic       data_role;
		logic [1:0] revision;
		logic       power_role;
	} header_fields_s;

	typedef struct packed {
		logic       valid;
		logic [2:0] kind;
	} frame_event_s;

	// true when the receive-detect bits accept this frame kind
	function automatic logic kind_enabled(input logic [7:0] en,
			input logic [2:0] kind);
		logic r;
		r = 1'b0;
		case (kind)
			KIND_PLAIN:       r = en[EN_PLAIN_BIT];
			KIND_SINGLE:      r = en[EN_SINGLE_BIT];
			KIND_DOUBLE:      r = en[EN_DOUBLE_BIT];
			KIND_DBG_SINGLE:  r = en[EN_DBG_SINGLE_BIT];
			KIND_DBG_DOUBLE:  r = en[EN_DBG_DOUBLE_BIT];
			KIND_HARD_RESET:  r = en[EN_HARD_RESET_BIT];
			KIND_CABLE_RESET: r = en[EN_CABLE_RESET_BIT];
			default:          r = 1'b0;
		endcase
		return r;
	endfunction
endpackage

// ### rtl/pd_phy_caps_header_rxdetect_regs.sv
// capability, message header and receive-detect register bank
`timescale 1ns/1ps
module pd_phy_caps_header_rxdetect_regs
	import pd_phy_regs_pkg::*;
(
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [7:0]   reg_addr_i,
	input  wire logic         reg_wr_i,
	input  wire logic         reg_rd_i,
	input  wire logic [7:0]   reg_wdata_i,
	output logic [7:0]        reg_rdata_o,
	output logic              reg_hit_o,
	input  wire frame_event_s rx_frame_i,
	input  wire logic         disconnect_i,
	output frame_event_s      rx_accepted_o,
	output logic              hard_reset_seen_o,
	output header_fields_s    header_o,
	output logic [7:0]        rx_kind_enable_o,
	output logic              rev3_features_o
);
	logic [7:0] message_header_config_ff;
	logic [7:0] receive_kind_enable_ff;
	logic       hard_reset_det;
	logic [7:0] nxt_rdata;
	logic       nxt_hit;

	rx_kind_filter u_filter (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.enable_i     (receive_kind_enable_ff),
		.frame_i      (rx_frame_i),
		.accepted_o   (rx_accepted_o),
		.hard_reset_o (hard_reset_det)
	);

	// the whole byte is writable, reserved bits included
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			message_header_config_ff <= RST_MSG_HDR_CFG;
		end else if (reg_wr_i && reg_addr_i == ADDR_MSG_HDR_CFG) begin
			message_header_config_ff <= reg_wdata_i;
		end
	end

	// hard reset wins over a same-cycle write; disconnect has no effect here
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			receive_kind_enable_ff <= RST_RX_KIND_EN;
		end else if (hard_reset_det) begin
			receive_kind_enable_ff <= RST_RX_KIND_EN;
		end else if (reg_wr_i && reg_addr_i == ADDR_RX_KIND_EN) begin
			receive_kind_enable_ff <= reg_wdata_i & RX_KIND_EN_MASK;
		end
	end

	always_comb begin
		nxt_rdata = 8'h00;
		nxt_hit = 1'b1;
		case (reg_addr_i)
			ADDR_EXT_CAP_UPPER: nxt_rdata = RST_EXT_CAP_UPPER;
			ADDR_INPUT_CAP:     nxt_rdata = RST_INPUT_CAP;
			ADDR_OUTPUT_CAP:    nxt_rdata = RST_OUTPUT_CAP;
			ADDR_MSG_HDR_CFG:   nxt_rdata = message_header_config_ff;
			ADDR_RX_KIND_EN:    nxt_rdata = receive_kind_enable_ff;
			default:            nxt_hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			reg_rdata_o <= 8'h00;
			reg_hit_o   <= 1'b0;
		end else if (reg_rd_i) begin
			reg_rdata_o <= nxt_rdata;
			reg_hit_o   <= nxt_hit;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			header_o          <= '0;
			rx_kind_enable_o  <= 8'h00;
			hard_reset_seen_o <= 1'b0;
			rev3_features_o   <= 1'b0;
		end else begin
			header_o.cable_plug <= message_header_config_ff[HDR_CABLE_PLUG_BIT];
			header_o.data_role  <= message_header_config_ff[HDR_DATA_ROLE_BIT];
			header_o.revision   <=
				message_header_config_ff[HDR_REV_LSB +: 2];
			header_o.power_role <= message_header_config_ff[HDR_POWER_ROLE_BIT];
			rx_kind_enable_o  <= receive_kind_enable_ff;
			hard_reset_seen_o <= hard_reset_det;
			rev3_features_o   <= 1'b1;
		end
	end

	property p_hdr_reset;
		@(posedge clk_i) $fell(rst_i) |-> message_header_config_ff == 8'h02;
	endproperty
	a_hdr_reset: assert property (p_hdr_reset) else $error("hdr reset");

	property p_hdr_write;
		@(posedge clk_i) disable iff (rst_i)
		reg_wr_i && reg_addr_i == ADDR_MSG_HDR_CFG
		|=> message_header_config_ff == $past(reg_wdata_i);
	endproperty
	a_hdr_write: assert property (p_hdr_write) else $error("hdr write");

	property p_hr_clear;
		@(posedge clk_i) disable iff (rst_i)
		rx_frame_i.valid && rx_frame_i.kind == KIND_HARD_RESET
		&& receive_kind_enable_ff[EN_HARD_RESET_BIT]
		|=> ##1 receive_kind_enable_ff == 8'h00;
	endproperty
	a_hr_clear: assert property (p_hr_clear) else $error("no clear");

	property p_disc_keep;
		@(posedge clk_i) disable iff (rst_i)
		disconnect_i && !reg_wr_i && !hard_reset_det
		|=> $stable(receive_kind_enable_ff);
	endproperty
	a_disc_keep: assert property (p_disc_keep) else $error("disc change");

	property p_caps_zero;
		@(posedge clk_i) disable iff (rst_i)
		reg_rd_i && (reg_addr_i == ADDR_INPUT_CAP
		|| reg_addr_i == ADDR_OUTPUT_CAP || reg_addr_i == ADDR_EXT_CAP_UPPER)
		|=> reg_rdata_o == 8'h00 && reg_hit_o;
	endproperty
	a_caps_zero: assert property (p_caps_zero) else $error("caps");

	property p_drop;
		@(posedge clk_i) disable iff (rst_i)
		rx_frame_i.valid && !kind_enabled(receive_kind_enable_ff,
			rx_frame_i.kind) |=> !rx_accepted_o.valid;
	endproperty
	a_drop: assert property (p_drop) else $error("frame leak");

	property p_pass;
		@(posedge clk_i) disable iff (rst_i)
		rx_frame_i.valid && kind_enabled(receive_kind_enable_ff,
			rx_frame_i.kind) |=> rx_accepted_o.valid;
	endproperty
	a_pass: assert property (p_pass) else $error("frame lost");

	property p_bit7;
		@(posedge clk_i) disable iff (rst_i) !receive_kind_enable_ff[7];
	endproperty
	a_bit7: assert property (p_bit7) else $error("bit7 set");

	property p_en_reset;
		@(posedge clk_i)
		$fell(rst_i) |-> receive_kind_enable_ff == RST_RX_KIND_EN;
	endproperty
	a_en_reset: assert property (p_en_reset) else $error("en reset");

	property p_rev_reset;
		@(posedge clk_i)
		$fell(rst_i)
		|-> message_header_config_ff[HDR_REV_LSB +: 2] == REV_2_0;
	endproperty
	a_rev_reset: assert property (p_rev_reset) else $error("rev");

	property p_en_wr;
		@(posedge clk_i) disable iff (rst_i)
		reg_wr_i && reg_addr_i == ADDR_RX_KIND_EN && !hard_reset_det
		|=> receive_kind_enable_ff
			== ($past(reg_wdata_i) & RX_KIND_EN_MASK);
	endproperty
	a_en_wr: assert property (p_en_wr) else $error("en write");

	property p_hr_wins;
		@(posedge clk_i) disable iff (rst_i)
		hard_reset_det |=> receive_kind_enable_ff == RST_RX_KIND_EN;
	endproperty
	a_hr_wins: assert property (p_hr_wins) else $error("hr clear");

	// only hardware clear and a host write may move the enables
	property p_en_hold;
		@(posedge clk_i) disable iff (rst_i)
		!hard_reset_det
		&& !(reg_wr_i && reg_addr_i == ADDR_RX_KIND_EN)
		|=> $stable(receive_kind_enable_ff);
	endproperty
	a_en_hold: assert property (p_en_hold) else $error("en moved");

	property p_hdr_hold;
		@(posedge clk_i) disable iff (rst_i)
		!(reg_wr_i && reg_addr_i == ADDR_MSG_HDR_CFG)
		|=> $stable(message_header_config_ff);
	endproperty
	a_hdr_hold: assert property (p_hdr_hold) else $error("hdr moved");

	property p_rd_hdr;
		@(posedge clk_i) disable iff (rst_i)
		reg_rd_i && reg_addr_i == ADDR_MSG_HDR_CFG
		|=> reg_rdata_o == $past(message_header_config_ff)
			&& reg_hit_o;
	endproperty
	a_rd_hdr: assert property (p_rd_hdr) else $error("hdr read");

	property p_rd_en;
		@(posedge clk_i) disable iff (rst_i)
		reg_rd_i && reg_addr_i == ADDR_RX_KIND_EN
		|=> reg_rdata_o == $past(receive_kind_enable_ff)
			&& reg_hit_o;
	endproperty
	a_rd_en: assert property (p_rd_en) else $error("en read");

	property p_hdr_plug;
		@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) |-> header_o.cable_plug
			== $past(message_header_config_ff[HDR_CABLE_PLUG_BIT]);
	endproperty
	a_hdr_plug: assert property (p_hdr_plug) else $error("plug");

	property p_hdr_data;
		@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) |-> header_o.data_role
			== $past(message_header_config_ff[HDR_DATA_ROLE_BIT]);
	endproperty
	a_hdr_data: assert property (p_hdr_data) else $error("data");

	property p_hdr_rev;
		@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) |-> header_o.revision
			== $past(message_header_config_ff[HDR_REV_LSB +: 2]);
	endproperty
	a_hdr_rev: assert property (p_hdr_rev) else $error("revision");

	property p_hdr_power;
		@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) |-> header_o.power_role
			== $past(message_header_config_ff[HDR_POWER_ROLE_BIT]);
	endproperty
	a_hdr_power: assert property (p_hdr_power) else $error("power");

	property p_en_copy;
		@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i)
		|-> rx_kind_enable_o == $past(receive_kind_enable_ff);
	endproperty
	a_en_copy: assert property (p_en_copy) else $error("en copy");

	property p_hr_seen;
		@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i)
		|-> hard_reset_seen_o == $past(hard_reset_det);
	endproperty
	a_hr_seen: assert property (p_hr_seen) else $error("hr seen");

	property p_rev3;
		@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) |-> rev3_features_o;
	endproperty
	a_rev3: assert property (p_rev3) else $error("rev3");

	property p_kind_copy;
		@(posedge clk_i) disable iff (rst_i)
		rx_frame_i.valid
		|=> rx_accepted_o.kind == $past(rx_frame_i.kind);
	endproperty
	a_kind_copy: assert property (p_kind_copy) else $error("kind");

	property p_hr_on;
		@(posedge clk_i) disable iff (rst_i)
		rx_frame_i.valid && rx_frame_i.kind == KIND_HARD_RESET
		&& receive_kind_enable_ff[EN_HARD_RESET_BIT]
		|=> hard_reset_det;
	endproperty
	a_hr_on: assert property (p_hr_on) else $error("hr missed");

	// a disabled hard reset must not wipe the enables
	property p_hr_off;
		@(posedge clk_i) disable iff (rst_i)
		rx_frame_i.valid && rx_frame_i.kind == KIND_HARD_RESET
		&& !receive_kind_enable_ff[EN_HARD_RESET_BIT]
		|=> !hard_reset_det;
	endproperty
	a_hr_off: assert property (p_hr_off) else $error("hr taken");

	property p_cr_keep;
		@(posedge clk_i) disable iff (rst_i)
		rx_frame_i.valid && rx_frame_i.kind == KIND_CABLE_RESET
		|=> !hard_reset_det;
	endproperty
	a_cr_keep: assert property (p_cr_keep) else $error("cable clr");

	// gates checked bit by bit, independent of the shared decode function
	property p_dbg2_gate;
		@(posedge clk_i) disable iff (rst_i)
		rx_frame_i.valid && rx_frame_i.kind == KIND_DBG_DOUBLE
		|=> rx_accepted_o.valid
			== $past(receive_kind_enable_ff[EN_DBG_DOUBLE_BIT]);
	endproperty
	a_dbg2_gate: assert property (p_dbg2_gate) else $error("dbg2");

	property p_dbg1_gate;
		@(posedge clk_i) disable iff (rst_i)
		rx_frame_i.valid && rx_frame_i.kind == KIND_DBG_SINGLE
		|=> rx_accepted_o.valid
			== $past(receive_kind_enable_ff[EN_DBG_SINGLE_BIT]);
	endproperty
	a_dbg1_gate: assert property (p_dbg1_gate) else $error("dbg1");

	property p_plain_gate;
		@(posedge clk_i) disable iff (rst_i)
		rx_frame_i.valid && rx_frame_i.kind == KIND_PLAIN
		|=> rx_accepted_o.valid
			== $past(receive_kind_enable_ff[EN_PLAIN_BIT]);
	endproperty
	a_plain_gate: assert property (p_plain_gate) else $error("plain");

	property p_cable_gate;
		@(posedge clk_i) disable iff (rst_i)
		rx_frame_i.valid && rx_frame_i.kind == KIND_CABLE_RESET
		|=> rx_accepted_o.valid
			== $past(receive_kind_enable_ff[EN_CABLE_RESET_BIT]);
	endproperty
	a_cable_gate: assert property (p_cable_gate) else $error("cable");
endmodule

// ### rtl/rx_kind_filter.sv
// gate that passes only enabled frame kinds to the receive path
`timescale 1ns/1ps
module rx_kind_filter
	import pd_phy_regs_pkg::*;
(
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [7:0]   enable_i,
	input  wire frame_event_s frame_i,
	output frame_event_s      accepted_o,
	output logic              hard_reset_o
);
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			accepted_o <= '0;
		end else begin
			accepted_o.valid <= frame_i.valid
				&& kind_enabled(enable_i, frame_i.kind);
			accepted_o.kind  <= frame_i.kind;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			hard_reset_o <= 1'b0;
		end else begin
			hard_reset_o <= frame_i.valid && frame_i.kind == KIND_HARD_RESET
				&& enable_i[EN_HARD_RESET_BIT];
		end
	end
endmodule

// ### verification/frame_source.sv
// receiver front end model that emits single-cycle frame events
`timescale 1ns/1ps
module frame_source
	import pd_phy_regs_pkg::*;
(
	input  wire logic    clk_i,
	output frame_event_s frame_o
);
	initial frame_o = '0;

	// idle shows an inverted kind so a stale value is never mistaken for data
	task automatic send(input logic [2:0] kind);
		@(negedge clk_i);
		frame_o = '{valid: 1'b1, kind: kind};
		@(negedge clk_i);
		frame_o = '{valid: 1'b0, kind: ~kind};
	endtask
endmodule

// ### verification/tb.sv
// self-checking bench for the capability, header and receive-detect bank
`timescale 1ns/1ps
module tb
	import pd_phy_regs_pkg::*;
;
	logic           clk_i        = 1'b0;
	logic           rst_i        = 1'b1;
	logic [7:0]     reg_addr_i   = 8'h00;
	logic           reg_wr_i     = 1'b0;
	logic           reg_rd_i     = 1'b0;
	logic [7:0]     reg_wdata_i  = 8'h00;
	logic           disconnect_i = 1'b0;
	logic [7:0]     reg_rdata_o;
	logic           reg_hit_o;
	frame_event_s   rx_frame_i;
	frame_event_s   rx_accepted_o;
	logic           hard_reset_seen_o;
	header_fields_s header_o;
	logic [7:0]     rx_kind_enable_o;
	logic           rev3_features_o;
	int             err_count    = 0;
	int             check_count  = 0;
	int             cycles       = 0;
	logic [7:0]     hdr_vals[2]  = '{8'h15, 8'he8};

	initial forever #5 clk_i = ~clk_i;

	pd_phy_caps_header_rxdetect_regs dut (
		.clk_i            (clk_i),
		.rst_i            (rst_i),
		.reg_addr_i       (reg_addr_i),
		.reg_wr_i         (reg_wr_i),
		.reg_rd_i         (reg_rd_i),
		.reg_wdata_i      (reg_wdata_i),
		.reg_rdata_o      (reg_rdata_o),
		.reg_hit_o        (reg_hit_o),
		.rx_frame_i       (rx_frame_i),
		.disconnect_i     (disconnect_i),
		.rx_accepted_o    (rx_accepted_o),
		.hard_reset_seen_o(hard_reset_seen_o),
		.header_o         (header_o),
		.rx_kind_enable_o (rx_kind_enable_o),
		.rev3_features_o  (rev3_features_o)
	);

	frame_source frm (
		.clk_i  (clk_i),
		.frame_o(rx_frame_i)
	);

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		reg_wr_i = 1'b1;
		reg_addr_i = a;
		reg_wdata_i = d;
		@(negedge clk_i);
		reg_wr_i = 1'b0;
		reg_addr_i = ~a;
		reg_wdata_i = ~d;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp,
			input logic hit);
		@(negedge clk_i);
		reg_rd_i = 1'b1;
		reg_addr_i = a;
		@(negedge clk_i);
		reg_rd_i = 1'b0;
		reg_addr_i = ~a;
		check(reg_rdata_o, exp);
		check({7'h0, reg_hit_o}, {7'h0, hit});
	endtask

	task automatic test_done();
		$display("checks=%0d errors=%0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ceiling far above the roughly 113 cycles the sequence needs
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			err_count++;
			test_done();
		end
	end

	initial begin
		repeat (2) @(negedge clk_i);
		rst_i = 1'b0;
		for (int a = 8'h27; a <= 8'h29; a++) begin
			rd_chk(8'(a), 8'h00, 1'b1);
			wr(8'(a), 8'hff);
			rd_chk(8'(a), 8'h00, 1'b1);
		end
		rd_chk(8'h2e, 8'h02, 1'b1);
		check({6'h0, header_o.revision}, 8'h01);
		check({7'h0, rev3_features_o}, 8'h01);
		rd_chk(8'h2f, 8'h00, 1'b1);
		rd_chk(8'h30, 8'h00, 1'b0);
		foreach (hdr_vals[i]) begin
			wr(8'h2e, hdr_vals[i]);
			rd_chk(8'h2e, hdr_vals[i], 1'b1);
			check({3'h0, header_o}, {3'h0, hdr_vals[i][4:0]});
			check({7'h0, rev3_features_o}, 8'h01);
		end
		// port manager sets the header back to its reset value 8'h02 before the detach
		wr(8'h2e, 8'h02);
		rd_chk(8'h2e, 8'h02, 1'b1);
		wr(8'h2f, 8'hff);
		rd_chk(8'h2f, 8'h7f, 1'b1);
		check(rx_kind_enable_o, 8'h7f);
		@(negedge clk_i);
		disconnect_i = 1'b1;
		@(negedge clk_i);
		disconnect_i = 1'b0;
		rd_chk(8'h2f, 8'h7f, 1'b1);
		wr(8'h2f, 8'h00);
		rd_chk(8'h2f, 8'h00, 1'b1);
		// each kind alone: its neighbour is refused, itself passes
		for (int k = 0; k < 7; k++) begin
			wr(8'h2f, 8'(1 << k));
			frm.send(3'((k + 1) % 7));
			check({7'h0, rx_accepted_o.valid}, 8'h00);
			frm.send(3'(k));
			check({4'h0, rx_accepted_o}, {4'h0, 1'b1, 3'(k)});
			@(negedge clk_i);
			check({7'h0, hard_reset_seen_o}, {7'h0, k == 5});
			rd_chk(8'h2f, (k == 5) ? 8'h00 : 8'(1 << k), 1'b1);
		end
		test_done();
	end
endmodule
